//--- uspc_pkg.sv
package uspc_pkg;

  // Register byte offsets
  localparam logic [7:0] PWR_CTRL_OFS   = 8'h00; // power_control_reg
  localparam logic [7:0] USB_PWR_OFS    = 8'h04; // usb_power_control_reg
  localparam logic [7:0] IRQ_EN_OFS     = 8'h08; // interrupt_enable_reg0
  localparam logic [7:0] STATUS_OFS     = 8'h0c; // mode and clock status

  // Field positions in power_control_reg
  localparam int IDLE_BIT   = 0;
  localparam int PDOWN_BIT  = 1;
  localparam int LOWCLK_BIT = 5;

  // Field positions in usb_power_control_reg
  localparam int GLOBAL_SUSPEND_FLAG_BIT = 0;
  localparam int GLOBAL_RESUME_FLAG_BIT = 1;
  localparam int RWU_BIT  = 2;

  // Field positions in interrupt_enable_reg0
  localparam int EX0_BIT = 0;
  localparam int EX1_BIT = 1;
  localparam int EX2_BIT = 2;

  // Reset values: low-clock set after reset
  localparam logic [7:0] PWR_CTRL_RST = 8'h20;

  // Timing
  localparam int CLK_MHZ        = 200;
  localparam int SUSPEND_US     = 3000;   // 3 ms inactivity
  localparam int SUSPEND_CYC    = SUSPEND_US * CLK_MHZ + 1;
  localparam int RESUME_US      = 10000;  // Remote wake-up drive time
  localparam int RESUME_CYC     = RESUME_US * CLK_MHZ;
  localparam int PLL_GATE_US    = 10;     // PLL settle before ungating
  localparam int PLL_GATE_CYC   = PLL_GATE_US * CLK_MHZ;
  localparam int SLOW_MHZ       = 3;
  localparam int SLOW_DIV       = CLK_MHZ / SLOW_MHZ / 2;

  // Power states
  typedef enum logic [1:0] {
    USPC_RUN,
    USPC_IDLE,
    USPC_PDOWN,
    USPC_WAKE
  } uspc_state_type;

endpackage

//--- uspc_timer.sv
`timescale 1ns/1ps
`default_nettype none
// Cycle counter with restart and terminal-count flag
module uspc_timer #(
  parameter int WIDTH = 24
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             ce,
  input  wire logic             restart,
  input  wire logic             run,
  input  wire logic [WIDTH-1:0] limit,
  output var  logic             done
);

  logic [WIDTH-1:0] cnt_q; // Elapsed cycles

  // Counts while run, saturates at limit
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt_q <= '0;
    else if (ce)
    begin
      if (restart || !run)
        cnt_q <= '0;
      else if (cnt_q != limit)
        cnt_q <= cnt_q + 1'b1;
    end
  end

  assign done = run && (cnt_q == limit);

endmodule
`default_nettype wire

//--- uspc_core.sv
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Suspend sets flag, raises shared interrupt
// - Idle bus over 3 ms is suspend
// - Suspend while suspended changes nothing
// - Suspend alone never cuts power
// - Powerdown stops oscillator unless isolated, freezes clocks
// - Powerdown pins: strobes low, ports per mode
// - Powerdown bit write enters powerdown immediately
// - Enabled external interrupt ends powerdown
// - Reset clears powerdown, restarts clocks
// - Resume sets resume flag, clears suspend
// - Any non-J state while suspended restarts oscillator
// - Resume powers PLL, output gated until timed
// - Remote wake starts from external interrupt
// - Wake bit drives resume signaling upstream
// - After reset CPU runs low clock
// - Clearing low-clock bit selects full rate
// - Isolation floats ports and strobes
// - Powerdown wins over idle
// - Wake bit self-clears after signaling
module uspc_core #(
  parameter int SUSPEND_CYC  = uspc_pkg::SUSPEND_CYC,
  parameter int RESUME_CYC   = uspc_pkg::RESUME_CYC,
  parameter int PLL_GATE_CYC = uspc_pkg::PLL_GATE_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        pce,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  // USB upstream line state
  input  wire logic        usb_line_j,
  input  wire logic        usb_activity,
  // External interrupt pins, active low
  input  wire logic        ext_irq0_pin,
  input  wire logic        ext_irq1_pin,
  input  wire logic        keyscan_irq_pin,
  // Reset-time straps
  input  wire logic        strap_strobe_hi,
  input  wire logic        strap_latch_lo,
  input  wire logic        external_code_select,
  // Clock and power controls
  output var  logic        osc_enable,
  output var  logic        pll_power,
  output var  logic        pll_out_enable,
  output var  logic        cpu_clk_enable,
  output var  logic        slow_clk_tick,
  output var  logic        susp_resume_irq,
  output var  logic        wake_irq,
  output var  logic        resume_drive,
  // Pin control
  output var  logic        addr_latch_o,
  output var  logic        addr_latch_oe,
  output var  logic        program_read_strobe_o,
  output var  logic        program_read_strobe_oe,
  output var  logic [3:0]  port_oe,
  output var  logic        port2_weak_pull
);

  localparam int TW = 32;

  // Control and status state
  uspc_pkg::uspc_state_type state_q, state_d;
  logic       idle_request_q;        // Idle request bit
  logic       powerdown_request_q;   // Powerdown request bit
  logic       low_clock_select_q;    // Low-clock select bit
  logic       global_suspend_flag_q; // Suspend flag
  logic       global_resume_flag_q;  // Resume flag
  logic       remote_wakeup_request_q; // Remote wake bit
  logic [2:0] irq_en_q;              // ext_irq enables
  logic       isolate_q;             // Isolation mode latched
  logic       strap_seen_q;          // Strap sampled once after reset
  logic       pll_wait_q;            // PLL output still gated
  logic [7:0] slow_cnt_q;            // Low-clock divider
  logic       slow_tick_q;

  // Bus decode
  wire        acc      = psel && penable;
  wire        wr       = acc && pwrite && pstrb[0];
  wire        hit_pc   = paddr == uspc_pkg::PWR_CTRL_OFS;
  wire        hit_up   = paddr == uspc_pkg::USB_PWR_OFS;
  wire        hit_ie   = paddr == uspc_pkg::IRQ_EN_OFS;
  wire        hit_st   = paddr == uspc_pkg::STATUS_OFS;
  wire        mapped   = hit_pc || hit_up || hit_ie || hit_st;
  wire        wr_pc    = wr && hit_pc;
  wire        wr_up    = wr && hit_up;
  wire        wr_ie    = wr && hit_ie;

  // Wake sources: active-low pins gated by enables
  wire [2:0]  ext_low  = {!keyscan_irq_pin, !ext_irq1_pin, !ext_irq0_pin};
  wire        ext_wake = |(ext_low & irq_en_q);
  // Resume: any departure from idle J while suspended
  wire        resume_ev = global_suspend_flag_q && !usb_line_j;
  wire        susp_done;
  wire        rwu_done;
  wire        pll_done;
  wire        susp_ev  = susp_done && !global_suspend_flag_q;
  wire        in_pd    = state_q == uspc_pkg::USPC_PDOWN;

  // Inactivity timer restarts on any bus activity
  uspc_timer #(.WIDTH(TW)) u_susp (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (pce),
    .restart (usb_activity),
    .run     (!global_suspend_flag_q),
    .limit   (TW'(SUSPEND_CYC)),
    .done    (susp_done)
  );

  // Remote wake signaling duration
  uspc_timer #(.WIDTH(TW)) u_rwu (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (pce),
    .restart (1'b0),
    .run     (remote_wakeup_request_q),
    .limit   (TW'(RESUME_CYC)),
    .done    (rwu_done)
  );

  // PLL settle before output ungated
  uspc_timer #(.WIDTH(TW)) u_pll (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (pce),
    .restart (1'b0),
    .run     (pll_wait_q),
    .limit   (TW'(PLL_GATE_CYC)),
    .done    (pll_done)
  );

  // Power state selection
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      uspc_pkg::USPC_RUN:
        if (wr_pc && pwdata[uspc_pkg::PDOWN_BIT])
          state_d = uspc_pkg::USPC_PDOWN;
        else if (wr_pc && pwdata[uspc_pkg::IDLE_BIT])
          state_d = uspc_pkg::USPC_IDLE;
      uspc_pkg::USPC_IDLE:
        if (ext_wake || resume_ev)
          state_d = uspc_pkg::USPC_RUN;
      uspc_pkg::USPC_PDOWN:
        if (ext_wake || resume_ev)
          state_d = uspc_pkg::USPC_WAKE;
      uspc_pkg::USPC_WAKE:
        if (pll_done)
          state_d = uspc_pkg::USPC_RUN;
      default:
        state_d = uspc_pkg::USPC_RUN;
    endcase
  end

  // State register; reset clears powerdown asynchronously
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_q <= uspc_pkg::USPC_RUN;
    else if (pce)
      state_q <= state_d;
  end

  // Power control bits
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      idle_request_q      <= 1'b0;
      powerdown_request_q <= 1'b0;
      low_clock_select_q  <= uspc_pkg::PWR_CTRL_RST[uspc_pkg::LOWCLK_BIT];
      irq_en_q            <= 3'h0;
    end
    else if (pce)
    begin
      // Wake clears request bits
      if (state_q != uspc_pkg::USPC_RUN && (ext_wake || resume_ev))
      begin
        idle_request_q      <= 1'b0;
        powerdown_request_q <= 1'b0;
      end
      else if (wr_pc)
      begin
        idle_request_q      <= pwdata[uspc_pkg::IDLE_BIT];
        powerdown_request_q <= pwdata[uspc_pkg::PDOWN_BIT];
      end
      if (wr_pc)
        low_clock_select_q <= pwdata[uspc_pkg::LOWCLK_BIT];
      if (wr_ie)
        irq_en_q <= pwdata[2:0];
    end
  end

  // USB suspend/resume flags; hardware set wins over clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      global_suspend_flag_q   <= 1'b0;
      global_resume_flag_q    <= 1'b0;
      remote_wakeup_request_q <= 1'b0;
    end
    else if (pce)
    begin
      if (susp_ev)
        global_suspend_flag_q <= 1'b1;
      else if (resume_ev)
        global_suspend_flag_q <= 1'b0;
      else if (wr_up && !pwdata[uspc_pkg::GLOBAL_SUSPEND_FLAG_BIT])
        global_suspend_flag_q <= 1'b0;
      if (resume_ev)
        global_resume_flag_q <= 1'b1;
      else if (wr_up && !pwdata[uspc_pkg::GLOBAL_RESUME_FLAG_BIT])
        global_resume_flag_q <= 1'b0;
      if (rwu_done)
        remote_wakeup_request_q <= 1'b0;
      else if (wr_up && pwdata[uspc_pkg::RWU_BIT])
        remote_wakeup_request_q <= 1'b1;
    end
  end

  // PLL gating after a resume from powerdown
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pll_wait_q <= 1'b0;
    else if (pce)
      pll_wait_q <= (state_d == uspc_pkg::USPC_WAKE);
  end

  // Strap sampled at first enabled edge after release
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      isolate_q    <= 1'b0;
      strap_seen_q <= 1'b0;
    end
    else if (pce && !strap_seen_q)
    begin
      strap_seen_q <= 1'b1;
      isolate_q    <= strap_strobe_hi && strap_latch_lo
                      && external_code_select;
    end
  end

  // Low-clock tick divider, free-running
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      slow_cnt_q  <= 8'h00;
      slow_tick_q <= 1'b0;
    end
    else if (pce)
    begin
      slow_tick_q <= slow_cnt_q == 8'(uspc_pkg::SLOW_DIV - 1);
      if (slow_cnt_q == 8'(uspc_pkg::SLOW_DIV - 1))
        slow_cnt_q <= 8'h00;
      else
        slow_cnt_q <= slow_cnt_q + 8'h01;
    end
  end

  // Clock and power outputs
  assign osc_enable      = !in_pd || isolate_q;
  assign pll_power       = !in_pd;
  assign pll_out_enable  = !in_pd && !pll_wait_q;
  assign cpu_clk_enable  = state_q == uspc_pkg::USPC_RUN;
  assign slow_clk_tick   = low_clock_select_q ? slow_tick_q : 1'b1;
  assign susp_resume_irq = global_suspend_flag_q || global_resume_flag_q;
  assign wake_irq        = ext_wake;
  assign resume_drive    = remote_wakeup_request_q;

  // Pins: powerdown drives strobes low, isolation floats all
  assign addr_latch_o           = !in_pd;
  assign addr_latch_oe          = !isolate_q;
  assign program_read_strobe_o  = !in_pd;
  assign program_read_strobe_oe = !isolate_q;
  assign port_oe[0] = !isolate_q && !(in_pd && !external_code_select);
  assign port_oe[1] = !isolate_q && !(in_pd && !external_code_select);
  assign port_oe[2] = !isolate_q && !(in_pd && !external_code_select);
  assign port_oe[3] = !isolate_q && !(in_pd && !external_code_select);
  assign port2_weak_pull = in_pd && !external_code_select && !isolate_q;

  // Read mux, registered in setup phase
  wire [31:0] rd_pc = {26'h0, low_clock_select_q, 3'h0,
                       powerdown_request_q, idle_request_q};
  wire [31:0] rd_up = {29'h0, remote_wakeup_request_q,
                       global_resume_flag_q, global_suspend_flag_q};
  wire [31:0] rd_st = {28'h0, isolate_q, pll_wait_q, state_q};
  wire [31:0] rd_mux = hit_pc ? rd_pc : hit_up ? rd_up :
                       hit_ie ? {29'h0, irq_en_q} : hit_st ? rd_st : 32'h0;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0;
    else if (pce && psel && !penable && !pwrite)
      prdata <= rd_mux;
  end

  assign pready  = pce;
  assign pslverr = acc && !mapped;

  // Checks
  property p_pd_enter;
    @(posedge pclk) disable iff (!presetn)
    (pce && state_q == uspc_pkg::USPC_RUN && wr_pc
     && pwdata[uspc_pkg::PDOWN_BIT]) |=> in_pd && !osc_enable == !isolate_q;
  endproperty
  a_pd_enter: assert property (p_pd_enter) else $error("no powerdown");

  property p_resume_flags;
    @(posedge pclk) disable iff (!presetn)
    (pce && resume_ev && !susp_ev) |=> global_resume_flag_q
      && !global_suspend_flag_q;
  endproperty
  a_resume_flags: assert property (p_resume_flags) else $error("resume");

  property p_pd_pins;
    @(posedge pclk) disable iff (!presetn)
    in_pd |-> !addr_latch_o && !program_read_strobe_o;
  endproperty
  a_pd_pins: assert property (p_pd_pins) else $error("pd pins");

  property p_no_auto_pd;
    @(posedge pclk) disable iff (!presetn)
    (state_q == uspc_pkg::USPC_RUN && !wr_pc) |=> !in_pd;
  endproperty
  a_no_auto_pd: assert property (p_no_auto_pd) else $error("auto pd");

  // Suspend detection must show as flag and shared interrupt
  property p_susp_set;
    @(posedge pclk) disable iff (!presetn)
    (pce && susp_ev) |=> global_suspend_flag_q && susp_resume_irq;
  endproperty
  a_susp_set: assert property (p_susp_set) else $error("no suspend");

  // Wake bit drops once its signaling span is over
  property p_rwu_clear;
    @(posedge pclk) disable iff (!presetn)
    (pce && rwu_done) |=> !remote_wakeup_request_q;
  endproperty
  a_rwu_clear: assert property (p_rwu_clear) else $error("wake bit");

  // Isolation floats every pin while the oscillator keeps running
  property p_isolate_pins;
    @(posedge pclk) disable iff (!presetn)
    isolate_q |-> !addr_latch_oe && !program_read_strobe_oe
      && port_oe == 4'h0 && osc_enable;
  endproperty
  a_isolate_pins: assert property (p_isolate_pins) else $error("iso");

  cover property (@(posedge pclk) susp_ev);
  cover property (@(posedge pclk) in_pd ##1 state_q == uspc_pkg::USPC_WAKE);
  cover property (@(posedge pclk) rwu_done);

endmodule
`default_nettype wire

//--- uspc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// Upstream host stand-in: idle J, busy traffic, or resume K
module uspc_host_model (
  input  wire logic       pclk,
  input  wire logic [1:0] mode,
  output var  logic       usb_line_j,
  output var  logic       usb_activity
);
  logic [1:0] phase_q = 2'h0; // Traffic phase, free running

  // Phase steps every cycle so traffic keeps moving
  always @(posedge pclk)
  begin
    phase_q <= phase_q + 2'h1;
  end

  // Traffic wiggles the line; resume leaves J for K and stays there
  always_comb
  begin
    usb_line_j   = (mode == 2'h2) ? 1'b0 : ((mode == 2'h1) ? phase_q[0] : 1'b1);
    // Gaps of three cycles, far below the inactivity span
    // K signaling is bus activity too, so it holds the timer off
    usb_activity = ((mode == 2'h1) && (phase_q == 2'h0))
                   || (mode == 2'h2);
  end
endmodule
`default_nettype wire

//--- usb_suspend_power_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench for the power-state controller
module usb_suspend_power_control_tb;
  logic        pclk, presetn, psel, penable, pwrite, pslverr, pready;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        line_j, activity, irq0_n, strb_hi, latch_lo, ext_code;
  logic        ce, irq1_n;
  logic [3:0]  strb;
  logic        osc, pll_pwr, pll_out, cpu_clk, slow_tick, sr_irq, wk_irq;
  logic        res_drv, ale_o, ale_oe, ps_o, ps_oe, weak_pull;
  logic [3:0]  port_oe;
  logic [1:0]  mode;
  logic [32:0] notes[$]; // Expected read data with error bit on top
  int          bad_count, tests_run, n;

  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // Short counts keep the run brief
  uspc_core #(.SUSPEND_CYC(50), .RESUME_CYC(40), .PLL_GATE_CYC(10)) uut (
    .pclk(pclk), .presetn(presetn), .pce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(strb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .usb_line_j(line_j), .usb_activity(activity), .ext_irq0_pin(irq0_n),
    .ext_irq1_pin(irq1_n), .keyscan_irq_pin(1'b1),
    .strap_strobe_hi(strb_hi), .strap_latch_lo(latch_lo),
    .external_code_select(ext_code), .osc_enable(osc),
    .pll_power(pll_pwr), .pll_out_enable(pll_out),
    .cpu_clk_enable(cpu_clk), .slow_clk_tick(slow_tick),
    .susp_resume_irq(sr_irq), .wake_irq(wk_irq), .resume_drive(res_drv),
    .addr_latch_o(ale_o), .addr_latch_oe(ale_oe),
    .program_read_strobe_o(ps_o), .program_read_strobe_oe(ps_oe),
    .port_oe(port_oe), .port2_weak_pull(weak_pull)
  );

  uspc_host_model host (
    .pclk(pclk), .mode(mode), .usb_line_j(line_j), .usb_activity(activity)
  );

  // Compare one value and count it
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; a read leaves its expectation in the queue
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, input logic [32:0] exp);
    @(posedge pclk);
    if (!wr)
      notes.push_back(exp);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Upper bits are random; only the low bits carry fields
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'($urandom()), d}, 33'h0);
  endtask

  // Read with compare on the masked low byte
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic err);
    apb(1'b0, a, 32'h0, {err, 24'h0, e});
  endtask

  // Watcher takes the oldest note at every completed read
  always @(posedge pclk)
  begin
    if (psel && penable && pready && !pwrite && notes.size() > 0)
    begin
      if (notes[0][32])
        check({31'h0, pslverr}, 32'h1);
      check(prdata & 32'hff, {24'h0, notes[0][7:0]});
      void'(notes.pop_front());
    end
  end

  // Wait a bounded span for osc to reach a level
  task automatic wait_osc(input logic v);
    for (n = 0; n < 100 && osc !== v; n++)
      @(posedge pclk);
  endtask

  // Reset for 12 cycles with chosen straps held through release
  task automatic reset_dut(input logic iso);
    presetn  <= 1'b0;
    strb_hi  <= iso;
    latch_lo <= iso;
    ext_code <= iso;
    repeat (12) @(posedge pclk);
    presetn  <= 1'b1;
    repeat (2) @(posedge pclk);
    strb_hi  <= 1'b0;
    latch_lo <= 1'b0;
  endtask

  // Counts, then the verdict
  task automatic complete_run;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Hang guard well beyond the planned run
  initial
  begin
    repeat (20000) @(posedge pclk);
    bad_count++;
    complete_run();
  end

  initial
  begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {ce, irq1_n, strb} = 6'h3f;
    {strb_hi, latch_lo, ext_code} = 3'h0;
    presetn = 1'b0;
    irq0_n  = 1'b1;
    mode    = 2'h1;
    void'($urandom(61));
    reset_dut(1'b0);
    rd(uspc_pkg::PWR_CTRL_OFS, uspc_pkg::PWR_CTRL_RST, 1'b0);
    rd(uspc_pkg::USB_PWR_OFS, 8'h0, 1'b0);
    rd(8'h10, 8'h0, 1'b1);
    // Write without the low byte lane must not land
    strb <= 4'he;
    wr(uspc_pkg::IRQ_EN_OFS, 8'h07);
    strb <= 4'hf;
    rd(uspc_pkg::IRQ_EN_OFS, 8'h0, 1'b0);
    n = 0;
    repeat (40) @(posedge pclk) n += (slow_tick === 1'b0);
    check(32'(n > 0), 32'h1);
    wr(uspc_pkg::PWR_CTRL_OFS, 8'h00);
    repeat (3) @(posedge pclk);
    n = 0;
    repeat (40) @(posedge pclk) n += (slow_tick === 1'b0);
    check(32'(n), 32'h0);
    // Long random traffic must never count as suspend
    repeat (100 + $urandom() % 100) @(posedge pclk);
    rd(uspc_pkg::USB_PWR_OFS, 8'h0, 1'b0);
    mode <= 2'h0;
    // Frozen clock enable must hold the inactivity timer
    ce <= 1'b0;
    repeat (60) @(posedge pclk);
    ce <= 1'b1;
    check({31'h0, sr_irq}, 32'h0);
    for (n = 0; n < 200 && sr_irq !== 1'b1; n++)
      @(posedge pclk);
    check(32'(n >= 45 && n <= 60), 32'h1);
    check({31'h0, sr_irq}, 32'h1);
    check({30'h0, osc, cpu_clk}, 32'h3);
    repeat (60) @(posedge pclk);
    rd(uspc_pkg::USB_PWR_OFS, 8'h1, 1'b0);
    // Idle and powerdown together: powerdown wins
    wr(uspc_pkg::PWR_CTRL_OFS, 8'h03);
    wait_osc(1'b0);
    check({30'h0, osc, cpu_clk}, 32'h0);
    check({28'h0, ale_o, ale_oe, ps_o, ps_oe}, 32'h5);
    check({27'h0, port_oe, weak_pull}, 32'h1);
    rd(uspc_pkg::STATUS_OFS, 8'h2, 1'b0);
    mode <= 2'h2;
    wait_osc(1'b1);
    check({31'h0, osc}, 32'h1);
    check({30'h0, pll_pwr, pll_out}, 32'h2);
    for (n = 0; n < 40 && pll_out !== 1'b1; n++)
      @(posedge pclk);
    check({31'h0, pll_out}, 32'h1);
    rd(uspc_pkg::USB_PWR_OFS, 8'h2, 1'b0);
    // Remote wake from an enabled external interrupt
    mode <= 2'h0;
    wr(uspc_pkg::USB_PWR_OFS, 8'h00);
    @(posedge pclk);
    for (n = 0; n < 100 && sr_irq !== 1'b1; n++)
      @(posedge pclk);
    check({31'h0, sr_irq}, 32'h1);
    wr(uspc_pkg::IRQ_EN_OFS, 8'h01);
    ext_code <= 1'b1;
    wr(uspc_pkg::PWR_CTRL_OFS, 8'h02);
    wait_osc(1'b0);
    check({27'h0, port_oe, weak_pull}, 32'h1e);
    // A pin without its enable must not wake
    irq1_n <= 1'b0;
    repeat (5) @(posedge pclk);
    check({30'h0, wk_irq, osc}, 32'h0);
    irq1_n <= 1'b1;
    irq0_n <= 1'b0;
    wait_osc(1'b1);
    check({30'h0, wk_irq, osc}, 32'h3);
    rd(uspc_pkg::PWR_CTRL_OFS, 8'h0, 1'b0);
    irq0_n <= 1'b1;
    wr(uspc_pkg::USB_PWR_OFS, 8'h05);
    @(posedge pclk);
    check({31'h0, res_drv}, 32'h1);
    for (n = 0; n < 80 && res_drv !== 1'b0; n++)
      @(posedge pclk);
    check(32'(n >= 35 && n <= 45), 32'h1);
    rd(uspc_pkg::USB_PWR_OFS, 8'h1, 1'b0);
    // Reset pin ends powerdown at once
    wr(uspc_pkg::PWR_CTRL_OFS, 8'h02);
    wait_osc(1'b0);
    presetn <= 1'b0;
    #1;
    check({31'h0, osc}, 32'h1);
    reset_dut(1'b1);
    repeat (3) @(posedge pclk);
    check({26'h0, port_oe, ale_oe, ps_oe}, 32'h0);
    check({31'h0, osc}, 32'h1);
    rd(uspc_pkg::STATUS_OFS, 8'h8, 1'b0);
    repeat (4) @(posedge pclk);
    complete_run();
  end
endmodule
`default_nettype wire
